// *** common/bdio_regs.vh ***
// Register offsets, field positions, reset values and core operation codes for the I/O ports
// ----------------------------------------------------------------------------
// Contract
// - A read of any port register returns the pin levels, never the output latch.
// - Every reset sets all direction bits to one so every pin comes up as an input.
// - The first port has four pins in its low bits and its upper four bits read as zero.
// - The second port has eight independently controlled pins on bits seven to zero.
// - Without a third port its address acts as a plain general-purpose data register.
// - The direction-load instruction copies the accumulator into that port's direction register.
// - A direction bit of one floats the pin and a zero drives it from the output latch.
// - Direction registers are write-only and no access reads them back.
// - Output latches hold their value until the next write to that port, even on input pins.
// - Port inputs are not latched, so a read returns the pin level at that moment.
// - Every pin has its own direction bit and is configured individually.
// - Bit set and bit clear read all pins, change one bit and write the whole port back.
// - Port writes land at the end of the instruction cycle and reads sample at its start.
// - Port data is unknown at power-up and unchanged across master clear and watchdog resets.
// ----------------------------------------------------------------------------
`ifndef BDIO_REGS_VH
`define BDIO_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define BDIO_ADDR_W 5
`define BDIO_OFS_PORT_A 5'h05
`define BDIO_OFS_PORT_B 5'h06
`define BDIO_OFS_PORT_C 5'h07

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define BDIO_PORT_A_PINS 4
`define BDIO_PORT_B_PINS 8
`define BDIO_PORT_C_PINS 8
`define BDIO_DIR_RESET 8'hff
`define BDIO_BIT_SEL_W 3

// ----------------------------------------------------------------------------
// Operation codes on the core side
// ----------------------------------------------------------------------------
`define BDIO_OP_W 3
`define BDIO_OP_NONE 3'h0
`define BDIO_OP_WRITE 3'h1
`define BDIO_OP_BSET 3'h2
`define BDIO_OP_BCLR 3'h3
`define BDIO_OP_DIR 3'h4

`endif

// *** core/bdio_pin_port.v ***
// One bidirectional port: output latch, write-only direction register and pin drivers
`default_nettype none

module bdio_pin_port #(
    parameter WIDTH = 8
) (
    // Clock and resets
    input wire clk_in,
    input wire rst_b_in,
    // Strobes from the port controller, applied at the end of the cycle
    input wire lat_we_in,
    input wire [WIDTH-1:0] lat_data_in,
    input wire dir_we_in,
    input wire [WIDTH-1:0] dir_data_in,
    // Pins
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe_out,
    // Live pin level for reads
    output wire [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] lat_q;
    reg [WIDTH-1:0] dir_q;

    // Latch has no reset so its content is unknown at power-up and kept otherwise
    always @(posedge clk_in)
    begin
        if (lat_we_in)
            lat_q <= lat_data_in;
    end

    // Direction comes up all inputs on every reset
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            dir_q <= {WIDTH{1'b1}};
        else if (dir_we_in)
            dir_q <= dir_data_in;
    end

    // One driver per pin; the direction register never feeds the read path
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_pin
            assign pin_oe_out[g] = ~dir_q[g];
            assign pin_out[g] = lat_q[g];
        end
    endgenerate

    // Reads see the pins directly, not the latch
    assign level_out = pin_in;

endmodule

`default_nettype wire

// *** core/bdio_ports.v ***
// I/O port block: address decode, read path, read-modify-write and direction loads
`include "bdio_regs.vh"
`default_nettype none

module bdio_ports #(
    parameter HAS_PORT_C = 1
) (
    // Clock and reset (power-on, master clear and watchdog reset combined)
    input wire clk_in,
    input wire rst_b_in,
    // Core side
    input wire [`BDIO_OP_W-1:0] op_in,
    input wire [`BDIO_ADDR_W-1:0] addr_in,
    input wire [`BDIO_BIT_SEL_W-1:0] bit_sel_in,
    input wire [7:0] acc_in,
    input wire rd_in,
    output reg [7:0] rd_data_out,
    output wire hit_out,
    // First port pins
    input wire [`BDIO_PORT_A_PINS-1:0] first_port_data_in,
    output wire [`BDIO_PORT_A_PINS-1:0] first_port_data_out,
    output wire [`BDIO_PORT_A_PINS-1:0] first_port_data_oe_out,
    // Second port pins
    input wire [`BDIO_PORT_B_PINS-1:0] second_port_data_in,
    output wire [`BDIO_PORT_B_PINS-1:0] second_port_data_out,
    output wire [`BDIO_PORT_B_PINS-1:0] second_port_data_oe_out,
    // Third port pins
    input wire [`BDIO_PORT_C_PINS-1:0] third_port_data_in,
    output wire [`BDIO_PORT_C_PINS-1:0] third_port_data_out,
    output wire [`BDIO_PORT_C_PINS-1:0] third_port_data_oe_out
);

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------

    // Shared decode of which port an address names, used by reads and writes
    function [2:0] port_sel;
        input [`BDIO_ADDR_W-1:0] a;
        begin
            port_sel = 3'h0;
            if (a == `BDIO_OFS_PORT_A)
                port_sel = 3'h1;
            else if (a == `BDIO_OFS_PORT_B)
                port_sel = 3'h2;
            else if (a == `BDIO_OFS_PORT_C)
                port_sel = 3'h4;
        end
    endfunction

    wire [2:0] sel = port_sel(addr_in);
    wire is_wr = (op_in == `BDIO_OP_WRITE);
    wire is_rmw = (op_in == `BDIO_OP_BSET) || (op_in == `BDIO_OP_BCLR);
    wire is_dir = (op_in == `BDIO_OP_DIR);
    wire [7:0] a_level;
    wire [7:0] b_level;
    wire [7:0] c_level;
    wire [7:0] c_reg_level;
    reg [7:0] gp_q;
    reg [7:0] cur_level;
    reg [7:0] wr_val;

    assign hit_out = |sel;

    // ------------------------------------------------------------------------
    // Read path and write value
    // ------------------------------------------------------------------------

    // Pins are sampled now for the start-of-cycle read and the modify step
    always @*
    begin
        cur_level = 8'h00;
        case (sel)
            3'h1: cur_level = a_level;
            3'h2: cur_level = b_level;
            3'h4: cur_level = c_reg_level;
            default: cur_level = 8'h00;
        endcase
    end

    // Bit operations rewrite every bit, so input pins latch their sampled level
    always @*
    begin
        wr_val = acc_in;
        case (op_in)
            `BDIO_OP_BSET: wr_val = cur_level | (8'h01 << bit_sel_in);
            `BDIO_OP_BCLR: wr_val = cur_level & ~(8'h01 << bit_sel_in);
            default: wr_val = acc_in;
        endcase
    end

    // Read data registered at the sampling edge
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rd_data_out <= 8'h00;
        else if (rd_in)
            rd_data_out <= cur_level;
    end

    wire lat_we = is_wr || is_rmw;

    // ------------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------------

    bdio_pin_port #(.WIDTH(`BDIO_PORT_A_PINS)) u_port_a (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .lat_we_in(lat_we && sel[0]),
        .lat_data_in(wr_val[`BDIO_PORT_A_PINS-1:0]),
        .dir_we_in(is_dir && sel[0]),
        .dir_data_in(acc_in[`BDIO_PORT_A_PINS-1:0]),
        .pin_in(first_port_data_in),
        .pin_out(first_port_data_out),
        .pin_oe_out(first_port_data_oe_out),
        .level_out(a_level[`BDIO_PORT_A_PINS-1:0])
    );
    assign a_level[7:`BDIO_PORT_A_PINS] = 4'h0;

    bdio_pin_port #(.WIDTH(`BDIO_PORT_B_PINS)) u_port_b (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .lat_we_in(lat_we && sel[1]),
        .lat_data_in(wr_val),
        .dir_we_in(is_dir && sel[1]),
        .dir_data_in(acc_in),
        .pin_in(second_port_data_in),
        .pin_out(second_port_data_out),
        .pin_oe_out(second_port_data_oe_out),
        .level_out(b_level)
    );

    generate
        if (HAS_PORT_C != 0)
        begin : g_port_c
            bdio_pin_port #(.WIDTH(`BDIO_PORT_C_PINS)) u_port_c (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .lat_we_in(lat_we && sel[2]),
                .lat_data_in(wr_val),
                .dir_we_in(is_dir && sel[2]),
                .dir_data_in(acc_in),
                .pin_in(third_port_data_in),
                .pin_out(third_port_data_out),
                .pin_oe_out(third_port_data_oe_out),
                .level_out(c_level)
            );
            assign c_reg_level = c_level;
        end
        else
        begin : g_gp_c
            // No pins: the address is plain storage, pins stay released
            assign c_level = 8'h00;
            assign c_reg_level = gp_q;
            assign third_port_data_out = 8'h00;
            assign third_port_data_oe_out = 8'h00;
        end
    endgenerate

    // Storage for the third address when there is no third port; unknown at power-up
    always @(posedge clk_in)
    begin
        if (lat_we && sel[2] && (HAS_PORT_C == 0))
            gp_q <= wr_val;
    end

endmodule

`default_nettype wire

// *** verif/bdio_board.sv ***
// Board-side model of the pins around one port
`default_nettype none
module bdio_board #(
    parameter int W = 8
) (
    // Driver from the block and the level imposed by outside circuitry
    input wire logic [W-1:0] out_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] ext_in,
    // Level seen on the wire
    output logic [W-1:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Floating pins follow the outside source, so a stale latch never shows through
    assign pin_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule
`default_nettype wire

// *** verif/bdio_ports_chk.sv ***
// Concurrent checks on the I/O port block
`include "bdio_regs.vh"
`default_nettype none
module bdio_ports_chk (
    input wire logic clk_in, rst_b_in, rd_in, hit_out,
    input wire logic [2:0] op_in, bit_sel_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] acc_in, rd_data_out,
    input wire logic [3:0] first_port_data_in, first_port_data_out, first_port_data_oe_out,
    input wire logic [7:0] second_port_data_in, second_port_data_out, second_port_data_oe_out
);
    // ------------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------------
    wire logic on_a = addr_in == `BDIO_OFS_PORT_A;
    wire logic on_b = addr_in == `BDIO_OFS_PORT_B;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    AST_RST_OE: assert property ($rose(rst_b_in) |->
        second_port_data_oe_out == 8'h00 && first_port_data_oe_out == 4'h0) else $error("pin driven after reset");
    AST_DIR_B: assert property (op_in == `BDIO_OP_DIR && on_b |=>
        second_port_data_oe_out == ~$past(acc_in)) else $error("direction load lost");
    AST_DIR_A: assert property (op_in == `BDIO_OP_DIR && on_a |=>
        first_port_data_oe_out == ~$past(acc_in[3:0])) else $error("direction bits wrong");
    AST_NO_PORT: assert property (op_in == `BDIO_OP_DIR && !hit_out |=>
        $stable(second_port_data_oe_out) && $stable(first_port_data_oe_out)) else $error("stray load");
    AST_HIT: assert property (hit_out == (addr_in inside {5'h05, 5'h06, 5'h07}))
        else $error("decode wrong");
    AST_RD_B: assert property (rd_in && on_b |=>
        rd_data_out == $past(second_port_data_in)) else $error("read not pin level");
    AST_RD_A: assert property (rd_in && on_a |=>
        rd_data_out == {4'h0, $past(first_port_data_in)}) else $error("upper bits not zero");
    AST_BSET_B: assert property (op_in == `BDIO_OP_BSET && on_b |=>
        second_port_data_out == ($past(second_port_data_in) | (8'h01 << $past(bit_sel_in))))
        else $error("bit set wrong");
    AST_BCLR_A: assert property (op_in == `BDIO_OP_BCLR && on_a |=>
        first_port_data_out == ($past(first_port_data_in) & ~(4'h1 << $past(bit_sel_in))))
        else $error("bit clear wrong");
    AST_HOLD_B: assert property (op_in == `BDIO_OP_WRITE && on_b ##1 op_in == `BDIO_OP_NONE |=>
        second_port_data_out == $past(acc_in, 2)) else $error("latch not held");
    // Main scenarios
    cover property (op_in == `BDIO_OP_BSET && on_b);
    cover property (rd_in && on_a);
    cover property ($rose(rst_b_in));
endmodule
bind bdio_ports bdio_ports_chk i_bdio_ports_chk (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the I/O port block
`include "bdio_regs.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------------
    // Stimulus, model and checks
    // ------------------------------------------------------------------------
    logic clk_in = 0, rst_b_in = 0, rd_in = 0, hit_out;
    logic [2:0] op_in = 0, bit_sel_in = 0;
    logic [4:0] addr_in = 0;
    logic [7:0] acc_in = 0, rd_data_out, b_o, b_oe, b_p, c_o, c_oe, c_p;
    logic [3:0] a_o, a_oe, a_p;
    logic [7:0] gp_rd, g_o, g_oe;
    logic gp_hit;
    logic [7:0] ext [3], lat [3], dir [3], vo [3], voe [3];
    logic [31:0] seed = 32'h1f4f;
    int mismatches = 0, compares = 0;
    always #25 clk_in = ~clk_in;
    always_comb
    begin
        vo = '{{4'h0, a_o}, b_o, c_o};
        voe = '{{4'h0, a_oe}, b_oe, c_oe};
    end
    bdio_ports #(.HAS_PORT_C(1)) i_bdio_ports (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .op_in(op_in), .addr_in(addr_in), .bit_sel_in(bit_sel_in), .acc_in(acc_in),
        .rd_in(rd_in), .rd_data_out(rd_data_out), .hit_out(hit_out),
        .first_port_data_in(a_p), .first_port_data_out(a_o), .first_port_data_oe_out(a_oe),
        .second_port_data_in(b_p), .second_port_data_out(b_o), .second_port_data_oe_out(b_oe),
        .third_port_data_in(c_p), .third_port_data_out(c_o), .third_port_data_oe_out(c_oe));
    bdio_board #(.W(4)) i_bdio_board_a (.out_in(a_o), .oe_in(a_oe), .ext_in(ext[0][3:0]), .pin_out(a_p));
    bdio_board i_bdio_board_b (.out_in(b_o), .oe_in(b_oe), .ext_in(ext[1]), .pin_out(b_p));
    bdio_board i_bdio_board_c (.out_in(c_o), .oe_in(c_oe), .ext_in(ext[2]), .pin_out(c_p));
    // Variant without a third port sees the same core traffic; its third address is storage
    bdio_ports #(.HAS_PORT_C(0)) i_bdio_ports_gp (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .op_in(op_in), .addr_in(addr_in), .bit_sel_in(bit_sel_in), .acc_in(acc_in),
        .rd_in(rd_in), .rd_data_out(gp_rd), .hit_out(gp_hit),
        .first_port_data_in(a_p), .first_port_data_out(), .first_port_data_oe_out(),
        .second_port_data_in(b_p), .second_port_data_out(), .second_port_data_oe_out(),
        .third_port_data_in(ext[2]), .third_port_data_out(g_o), .third_port_data_oe_out(g_oe));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // Port A has four pins only
    function automatic logic [7:0] m(int p);
        return (p == 0) ? 8'h0f : 8'hff;
    endfunction
    function automatic logic [7:0] lv(int p);
        return ((dir[p] & ext[p]) | (~dir[p] & lat[p])) & m(p);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every operation is followed by an idle cycle, keeping writes apart from reads
    task automatic op(input logic [2:0] o, input logic [4:0] a, input logic [2:0] b,
        input logic [7:0] d, input logic r);
        @(negedge clk_in);
        {op_in, addr_in, bit_sel_in, acc_in, rd_in} = {o, a, b, d, r};
        @(negedge clk_in);
        {op_in, rd_in} = 4'h0;
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        logic [7:0] v;
        for (int p = 0; p < 3; p++) ext[p] = rnd();
        repeat (20) @(negedge clk_in);
        chk(voe[0] | voe[1] | voe[2] | rd_data_out, 8'h00);
        rst_b_in = 1;
        repeat (4) for (int p = 0; p < 3; p++)
        begin
            ext[p] = rnd();
            dir[p] = rnd();
            op(`BDIO_OP_DIR, 5'h05 + 5'(p), 0, dir[p], 0);
            chk(voe[p], ~dir[p] & m(p));
            lat[p] = rnd();
            op(`BDIO_OP_WRITE, 5'h05 + 5'(p), 0, lat[p], 0);
            lat[p] = lat[p] & m(p);
            op(`BDIO_OP_NONE, 5'h05 + 5'(p), 0, 0, 1);
            chk(rd_data_out, lv(p));
            chk({7'h00, hit_out}, 8'h01);
            if (p == 2) chk(gp_rd, lat[p]);
            if (p == 2) chk(g_oe | g_o, 8'h00);
            v = rnd();
            op(`BDIO_OP_BSET, 5'h05 + 5'(p), v[2:0], 0, 0);
            lat[p] = (lv(p) | (8'h01 << v[2:0])) & m(p);
            chk(vo[p], lat[p]);
            op(`BDIO_OP_BCLR, 5'h05 + 5'(p), v[5:3], 0, 0);
            lat[p] = lv(p) & ~(8'h01 << v[5:3]) & m(p);
            chk(vo[p], lat[p]);
        end
        op(`BDIO_OP_DIR, 5'h08, 0, 8'h00, 0);
        for (int p = 0; p < 3; p++) chk(voe[p], ~dir[p] & m(p));
        chk({7'h00, hit_out}, 8'h00);
        rst_b_in = 0;
        repeat (2) @(negedge clk_in);
        chk(voe[0] | voe[1] | voe[2], 8'h00);
        for (int p = 0; p < 3; p++) chk(vo[p], lat[p]);
        rst_b_in = 1;
        for (int p = 0; p < 3; p++) dir[p] = 8'hff;
        op(`BDIO_OP_NONE, 5'h06, 0, 0, 1);
        chk(rd_data_out, lv(1));
        final_report();
    end
    // Run needs about 150 cycles
    initial
    begin
        #(50 * 1000);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
